// File: gpa8_cfg.svh
// register offsets, reset values and field layout of the eight-bit port
`ifndef GPA8_CFG_SVH
`define GPA8_CFG_SVH

`define GPA8_OFF_PIN_DIR    12'h000
`define GPA8_OFF_OUT_LATCH  12'h004
`define GPA8_OFF_STANDBY    12'h008
`define GPA8_ADDR_W         12
`define GPA8_DIR_RESET      8'h00
`define GPA8_LATCH_RESET    8'h00
`define GPA8_PULLUP_RESET   8'h00
`define GPA8_STBY_RESET     2'b00
`define GPA8_STBY_HW_BIT    0
`define GPA8_STBY_SW_BIT    1
`define GPA8_RESP_OKAY      2'b00
`define GPA8_RESP_SLVERR    2'b10

`endif

// File: gpa8_pkg.sv
// types shared by the eight-bit port modules
`default_nettype none
package gpa8_pkg;
  typedef logic [7:0] gpa8_byte_t;
  typedef enum logic [1:0] {
    GPA8_RUN     = 2'b00,
    GPA8_SW_STBY = 2'b01,
    GPA8_HW_STBY = 2'b11
  } gpa8_mode_e;
endpackage
`default_nettype wire

// File: gpa8_pad_if.sv
// interface carrying pin control and pin levels between core and pad logic
`timescale 1ns/1ps
`default_nettype none
interface gpa8_pad_if;
  gpa8_pkg::gpa8_byte_t direction;
  gpa8_pkg::gpa8_byte_t latch;
  gpa8_pkg::gpa8_mode_e mode;
  gpa8_pkg::gpa8_byte_t pin_level;
  modport core (output direction, output latch, output mode, input pin_level);
  modport pad  (input direction, input latch, input mode, output pin_level);
endinterface
`default_nettype wire

// File: gpa8_sync.sv
// two-stage synchroniser for a vector of pin levels
`timescale 1ns/1ps
`default_nettype none
module gpa8_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  // no reset: pin state has no defined value, it follows the pins
  always_ff @(posedge clk) begin
    stage1   <= async_in;
    sync_out <= stage1;
  end
endmodule // gpa8_sync
`default_nettype wire

// File: gpa8_pad.sv
// pad control: output enables, output values and pull-up control per pin
`timescale 1ns/1ps
`default_nettype none
`include "gpa8_cfg.svh"
module gpa8_pad (
  input  wire logic     clk,
  input  wire logic     reset,
  input  wire logic [7:0] pin_in,
  output var  logic [7:0] pin_out,
  output var  logic [7:0] pin_oe,
  output var  logic [7:0] pullup_en,
  gpa8_pad_if.pad       pad
);
  wire logic [7:0] next_pullup;
  wire logic [7:0] sync_level;

  // ****************************************************************
  // pull-up control
  // ****************************************************************
  // sw standby freezes the last state; hw standby forces off
  assign next_pullup =
    (pad.mode == gpa8_pkg::GPA8_HW_STBY) ? 8'h00 :
    (pad.mode == gpa8_pkg::GPA8_SW_STBY) ? pullup_en :
    (~pad.direction & pad.latch);

  always_ff @(posedge clk) begin
    if (reset) begin
      pin_out   <= `GPA8_LATCH_RESET;
      pin_oe    <= `GPA8_DIR_RESET;
      pullup_en <= `GPA8_PULLUP_RESET;
    end else begin
      pin_out   <= pad.latch;
      pin_oe    <= pad.direction;
      pullup_en <= next_pullup;
    end
  end

  // ****************************************************************
  // pin readback
  // ****************************************************************
  gpa8_sync #(.WIDTH(8)) u_sync (
    .clk      (clk),
    .async_in (pin_in),
    .sync_out (sync_level)
  );
  assign pad.pin_level = sync_level;
endmodule // gpa8_pad
`default_nettype wire

// File: gpa8_port.sv
// eight-bit general-purpose port with AXI4-Lite register access
//
// Implementation choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "gpa8_cfg.svh"

// Function
// - eight pins, each with its own direction, output and pull-up bit.
// - direction bit 1 makes output, 0 makes input; resets to zero.
// - direction is write-only; reading its address returns pin levels.
// - writing the pin-state address stores the value as directions.
// - pin-state read returns the actual pin levels, whatever the direction.
// - pin state has no reset value; it follows the pins.
// - output latch is read/write, resets to zero, drives output pins.
// - direction 1 gives a general output even when chosen as event source.
// - pull-up on only when direction is 0 and latch is 1.
// - pull-ups forced off during reset and hardware standby.
// - on software standby entry each pull-up keeps its state.
module gpa8_port (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [7:0]  pin_in,
  output var  logic [7:0]  pin_out,
  output var  logic [7:0]  pin_oe,
  output var  logic [7:0]  pullup_en,
  output var  logic [7:0]  event_counter_input
);
  gpa8_pad_if pad_bus ();

  logic [11:0]          wr_addr;
  logic [7:0]           wr_data;
  logic                 wr_lane0;
  logic                 aw_held;
  logic                 w_held;
  gpa8_pkg::gpa8_byte_t pin_direction_bit;
  gpa8_pkg::gpa8_byte_t pin_output_bit;
  logic [1:0]           standby_ctrl;

  // one decode serves both channels, so reads and writes see the same map
  function automatic logic [2:0] reg_select(input logic [11:0] addr);
    reg_select = {addr == `GPA8_OFF_STANDBY, addr == `GPA8_OFF_OUT_LATCH,
                  addr == `GPA8_OFF_PIN_DIR};
  endfunction

  // ****************************************************************
  // write channel
  // ****************************************************************
  wire logic aw_take  = s_axi_awvalid & s_axi_awready;
  wire logic w_take   = s_axi_wvalid & s_axi_wready;
  wire logic aw_have  = aw_held | aw_take;
  wire logic w_have   = w_held | w_take;
  wire logic [11:0] eff_waddr = aw_take ? s_axi_awaddr : wr_addr;
  wire logic [7:0]  eff_wdata = w_take ? s_axi_wdata[7:0] : wr_data;
  wire logic        eff_lane0 = w_take ? s_axi_wstrb[0] : wr_lane0;
  wire logic do_write = aw_have & w_have & ~s_axi_bvalid;
  wire logic [2:0] wr_sel = reg_select(eff_waddr);
  wire logic hit_dir  = wr_sel[0];
  wire logic hit_lat  = wr_sel[1];
  wire logic hit_stb  = wr_sel[2];
  wire logic wr_known = |wr_sel;

  always_ff @(posedge clk) begin
    if (reset) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      wr_addr       <= 12'h000;
      wr_data       <= 8'h00;
      wr_lane0      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `GPA8_RESP_OKAY;
    end else begin
      if (aw_take) begin
        wr_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        wr_data  <= s_axi_wdata[7:0];
        wr_lane0 <= s_axi_wstrb[0];
      end
      aw_held <= aw_have & ~do_write;
      w_held  <= w_have & ~do_write;
      // one outstanding write: ready drops once a channel is held
      s_axi_awready <= ~aw_have & ~s_axi_bvalid & ~do_write & ~s_axi_awready;
      s_axi_wready  <= ~w_have & ~s_axi_bvalid & ~do_write & ~s_axi_wready;
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? `GPA8_RESP_OKAY : `GPA8_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // port registers
  // ****************************************************************
  // narrow data sits in byte lane 0; other lanes are ignored
  always_ff @(posedge clk) begin
    if (reset) begin
      pin_direction_bit <= `GPA8_DIR_RESET;
      pin_output_bit    <= `GPA8_LATCH_RESET;
      standby_ctrl      <= `GPA8_STBY_RESET;
    end else if (do_write & eff_lane0) begin
      if (hit_dir) begin
        pin_direction_bit <= eff_wdata;
      end
      if (hit_lat) begin
        pin_output_bit <= eff_wdata;
      end
      if (hit_stb) begin
        standby_ctrl <= eff_wdata[1:0];
      end
    end
  end

  // hw standby outranks sw standby
  assign pad_bus.direction = pin_direction_bit;
  assign pad_bus.latch     = pin_output_bit;
  assign pad_bus.mode = standby_ctrl[`GPA8_STBY_HW_BIT] ? gpa8_pkg::GPA8_HW_STBY :
                        standby_ctrl[`GPA8_STBY_SW_BIT] ? gpa8_pkg::GPA8_SW_STBY :
                        gpa8_pkg::GPA8_RUN;

  gpa8_pad u_pad (
    .clk       (clk),
    .reset     (reset),
    .pin_in    (pin_in),
    .pin_out   (pin_out),
    .pin_oe    (pin_oe),
    .pullup_en (pullup_en),
    .pad       (pad_bus.pad)
  );

  // ****************************************************************
  // event inputs
  // ****************************************************************
  // selection lives elsewhere; an output pin still feeds back its own level
  always_ff @(posedge clk) begin
    event_counter_input <= pad_bus.pin_level;
  end

  // ****************************************************************
  // read channel
  // ****************************************************************
  wire logic [2:0] rd_sel = reg_select(s_axi_araddr);
  wire logic rd_dir = rd_sel[0];
  wire logic rd_lat = rd_sel[1];
  wire logic rd_stb = rd_sel[2];
  wire logic [31:0] rd_value =
    rd_dir ? {24'h000000, pad_bus.pin_level} :
    rd_lat ? {24'h000000, pin_output_bit} :
    rd_stb ? {30'h00000000, standby_ctrl} : 32'h00000000;
  wire logic ar_take = s_axi_arvalid & s_axi_arready;

  always_ff @(posedge clk) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `GPA8_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & ~ar_take;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_value;
        s_axi_rresp  <= (rd_dir | rd_lat | rd_stb) ? `GPA8_RESP_OKAY : `GPA8_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // gpa8_port
`default_nettype wire

// File: gpa8_port_chk.sv
// concurrent checks on the pins and bus handshakes of the eight-bit port
`timescale 1ns/1ps
`default_nettype none
`include "gpa8_cfg.svh"
module gpa8_port_chk (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [7:0]  pin_in,
  input wire logic [7:0]  pin_oe,
  input wire logic [7:0]  pin_out,
  input wire logic [7:0]  pullup_en,
  input wire logic [7:0]  event_counter_input
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic [1:0] stby_q;
  logic [1:0] cnt;
  // the sync chain is not reset, so allow a few edges before comparing its output
  logic [2:0] up;
  wire logic  stby_wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    && s_axi_awaddr == `GPA8_OFF_STANDBY && s_axi_wstrb[0];
  always_ff @(posedge clk) begin
    if (reset) up <= 3'h0;
    else up <= up + {2'h0, up != 3'h7};
    if (reset) stby_q <= 2'h0;
    else if (stby_wr) stby_q <= s_axi_wdata[1:0];
    if (reset || stby_wr) cnt <= 2'h0;
    else if (cnt != 2'h3) cnt <= cnt + 2'h1;
  end
  reset_clear_a: assert property (disable iff (1'b0) reset |=>
    pin_oe == 8'h00 && pin_out == 8'h00 && pullup_en == 8'h00) else $error("pins not cleared");
  pull_run_a: assert property (stby_q == 2'h0 && cnt == 2'h3 |->
    pullup_en == (~pin_oe & pin_out)) else $error("pull-up mismatch in run");
  pull_hw_a: assert property (stby_q[`GPA8_STBY_HW_BIT] && cnt == 2'h3 |->
    pullup_en == 8'h00) else $error("pull-up on in hardware standby");
  pull_sw_a: assert property (stby_q == 2'h2 && cnt >= 2'h2 && !stby_wr |=>
    $stable(pullup_en)) else $error("pull-up moved in software standby");
  event_sync_a: assert property (up == 3'h7 |->
    event_counter_input == $past(pin_in, 3)) else $error("event input not three edges late");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> s_axi_bvalid) else $error("no write response");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read data");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  cover property (stby_q == 2'h2 && cnt == 2'h3);
  cover property (s_axi_rvalid && !s_axi_rready);
  cover property (pullup_en != 8'h00 && pin_oe != 8'h00);
endmodule // gpa8_port_chk
bind gpa8_port gpa8_port_chk u_chk (.clk, .reset, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .pin_in, .pin_oe, .pin_out, .pullup_en, .event_counter_input);
`default_nettype wire

// File: gpa8_board.sv
// board model: each pin is driven by the port, an outside driver or its pull-up
`timescale 1ns/1ps
`default_nettype none
module gpa8_board (
  input  wire logic       clk,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pullup_en,
  input  wire logic [7:0] ext_level,
  input  wire logic [7:0] ext_drive,
  output var  logic [7:0] pin_in
);
  logic [7:0] last = 8'h00;
  // a floating pin toggles so that a stale level is never mistaken for a real one
  always @(posedge clk) last <= pin_in;
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_drive & ext_level)
    | (~pin_oe & ~ext_drive & (pullup_en | ~last));
endmodule // gpa8_board
`default_nettype wire

// File: tb_gpio_port_a_eight_bit.sv
// self-checking bench for the eight-bit port
`timescale 1ns/1ps
`default_nettype none
`include "gpa8_cfg.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb_gpio_port_a_eight_bit;
  localparam logic [11:0] a_pin = `GPA8_OFF_PIN_DIR;
  localparam logic [11:0] a_lat = `GPA8_OFF_OUT_LATCH;
  localparam logic [11:0] a_stb = `GPA8_OFF_STANDBY;
  logic        clk = 1'b0, reset = 1'b1;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [7:0]  pin_in, pin_out, pin_oe, pullup_en, event_counter_input;
  logic [7:0]  ext_level = 8'ha5, ext_drive = 8'hff;
  int          mismatches = 0, checked = 0;
  always #25 clk = ~clk;
  gpa8_port DUT (.clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .pin_in, .pin_out, .pin_oe, .pullup_en, .event_counter_input);
  gpa8_board board (.clk, .pin_out, .pin_oe, .pullup_en, .ext_level, .ext_drive, .pin_in);
  task automatic wrap_up;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic tmo(input int n);
    if (n >= 20) begin
      mismatches++;
      wrap_up();
    end
  endtask
  // the answer is accepted late on purpose, so the response must stand while stalled
  task automatic wr(input logic [11:0] a, input logic [7:0] v, input logic [3:0] s);
    int n;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, v};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (n == 3) s_axi_bready <= 1'b1;
      if (s_axi_bvalid && s_axi_bready) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    tmo(n);
  endtask
  task automatic rd(input logic [11:0] a);
    int n;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (n == 3) s_axi_rready <= 1'b1;
      if (s_axi_rvalid && s_axi_rready) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    tmo(n);
  endtask
  task automatic settle;
    repeat (4) @(posedge clk);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    settle();
    `CHK(pin_oe, 8'h00)
    `CHK(pullup_en, 8'h00)
    rd(a_lat);
    `CHK(d, 32'h0)
    rd(a_pin);
    `CHK(d, 32'ha5)
    wr(a_lat, 8'h3c, 4'hf);
    wr(a_pin, 8'h0f, 4'hf);
    ext_level <= 8'h5a;
    settle();
    `CHK(pin_oe, 8'h0f)
    `CHK(pin_out, 8'h3c)
    `CHK(pullup_en, 8'h30)
    `CHK(event_counter_input, 8'h5c)
    rd(a_pin);
    `CHK(d, 32'h5c)
    ext_drive <= 8'hc0;
    ext_level <= 8'h00;
    settle();
    rd(a_pin);
    `CHK(d, 32'h3c)
    wr(a_stb, 8'h02, 4'hf);
    wr(a_lat, 8'h00, 4'hf);
    settle();
    `CHK(pullup_en, 8'h30)
    wr(a_stb, 8'h03, 4'hf);
    settle();
    `CHK(pullup_en, 8'h00)
    wr(a_stb, 8'h00, 4'hf);
    wr(a_lat, 8'hff, 4'hf);
    settle();
    `CHK(pullup_en, 8'hf0)
    wr(a_lat, 8'h00, 4'h0);
    `CHK(r, `GPA8_RESP_OKAY)
    rd(a_lat);
    `CHK(d, 32'hff)
    wr(12'h00c, 8'h11, 4'hf);
    `CHK(r, `GPA8_RESP_SLVERR)
    rd(12'h00c);
    `CHK(r, `GPA8_RESP_SLVERR)
    `CHK(d, 32'h0)
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    `CHK(pin_oe, 8'h00)
    `CHK(pullup_en, 8'h00)
    rd(a_lat);
    `CHK(d, 32'h0)
    wrap_up();
  end
endmodule // tb_gpio_port_a_eight_bit
`default_nettype wire
